// ===== logic/adc_conversion_clocking_defines.svh
// What this block does
// - external mode: serial clock is master clock
// - external mode: one word per 612 clocks
// - oscillator mode: 64 kHz, 612 periods per word
// - oscillator mode: serial clock never times conversions
// - conversions start by themselves after reset
// - asynchronous read clock up to 2 MHz, synchronised
// - external mode: read bit rate equals master clock
// - word ready and select low: data out low, in external mode only from the first clock rise
// - twenty-four clock cycles shift one word, twenty-five in external mode
// - clock held high 200 to 2000 us: sleep
// - clock low 10 us wakes, conversions resume
`ifndef ADC_CONVERSION_CLOCKING_DEFINES_SVH
`define ADC_CONVERSION_CLOCKING_DEFINES_SVH
`define CONV_DIV 612
`define CONV_CNT_W 10
`define WORD_BITS 24
`define BIT_CNT_W 5
`define WORD_LAST_BIT 23
`define CLK_FREQ_KHZ 125000
`define INTERNAL_OSC_FREQ_KHZ 64
`define OSC_DIV_CYC (`CLK_FREQ_KHZ / `INTERNAL_OSC_FREQ_KHZ)
`define SLEEP_ENTRY_MIN_US 200
`define SLEEP_ENTRY_MAX_US 2000
`define SLEEP_ENTRY_CYC ((`SLEEP_ENTRY_MIN_US * `CLK_FREQ_KHZ + 999) / 1000)
`define WAKE_LOW_MIN_US 10
`define WAKE_LOW_CYC ((`WAKE_LOW_MIN_US * `CLK_FREQ_KHZ + 999) / 1000)
`define EARLY_RISE_OSC 17
`endif

// ===== logic/adc_conversion_clocking_pkg.sv
package adc_conversion_clocking_pkg;
  // conversion word as it leaves the filter, msb first on the wire
  typedef struct packed {
    logic lead_zero;
    logic overrange;
    logic osc_detect;
    logic pad_zero;
    logic [19:0] data;
  } conv_word_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READY = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_SLEEP = 4'b1000
  } port_state_t;
endpackage : adc_conversion_clocking_pkg

// ===== logic/adc_conversion_clocking.sv
`timescale 1ns/1ps
`include "adc_conversion_clocking_defines.svh"
module adc_conversion_clocking
  import adc_conversion_clocking_pkg::*;
#(
  parameter bit INT_OSC = 1'b0,
  parameter int CNT_W = 16,
  parameter int OSC_DIV_CYC = `OSC_DIV_CYC,
  parameter int SLEEP_ENTRY_CYC = `SLEEP_ENTRY_CYC,
  parameter int WAKE_LOW_CYC = `WAKE_LOW_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // serial port pins
  input wire logic i_sclk,
  input wire logic i_cs_b,
  output logic o_serial_data_out,
  output logic o_serial_data_out_oe,
  // filter side
  input wire conv_word_t i_conv_word,
  output logic o_conv_done,
  output logic o_asleep
);

  localparam int CONV_LAST = `CONV_DIV - 1;
  localparam int EARLY_RISE_AT = `CONV_DIV - `EARLY_RISE_OSC;

  // pin synchronisers; stage one feeds stage two only
  logic sclk_s1_q;
  logic sclk_s2_q;
  logic sclk_s3_q;
  logic cs_s1_q;
  logic cs_s2_q;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      cs_s1_q <= 1'b1;
      cs_s2_q <= 1'b1;
    end else begin
      sclk_s1_q <= i_sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      cs_s1_q <= i_cs_b;
      cs_s2_q <= cs_s1_q;
    end
  end

  assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
  assign sclk_fall = ~sclk_s2_q & sclk_s3_q;

  // timing and port state
  logic [CNT_W-1:0] osc_cnt_q;
  logic [CNT_W-1:0] osc_cnt_d;
  logic [`CONV_CNT_W-1:0] conv_cnt_q;
  logic [`CONV_CNT_W-1:0] conv_cnt_d;
  logic [CNT_W-1:0] hi_cnt_q;
  logic [CNT_W-1:0] hi_cnt_d;
  logic [CNT_W-1:0] lo_cnt_q;
  logic [CNT_W-1:0] lo_cnt_d;
  logic [`BIT_CNT_W-1:0] bit_q;
  logic [`BIT_CNT_W-1:0] bit_d;
  logic skip_q;
  logic skip_d;
  conv_word_t word_q;
  conv_word_t word_d;
  port_state_t state_q;
  port_state_t state_d;
  logic sdo_q;
  logic sdo_d;
  logic sdo_oe_q;
  logic sdo_oe_d;
  logic done_q;
  logic done_d;
  logic asleep_q;
  logic asleep_d;
  logic osc_tick;
  logic master_tick;
  logic conv_end;

  // on-chip oscillator stand-in: enable pulse at the nominal rate
  always_comb begin
    osc_tick = 1'b0;
    if (osc_cnt_q == CNT_W'(OSC_DIV_CYC - 1)) begin
      osc_cnt_d = '0;
      osc_tick = 1'b1;
    end else begin
      osc_cnt_d = osc_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      osc_cnt_q <= '0;
    end else begin
      osc_cnt_q <= osc_cnt_d;
    end
  end

  // idle-level watch; saturates so a parked pin never wraps under the threshold
  always_comb begin
    hi_cnt_d = '0;
    lo_cnt_d = '0;
    if (sclk_s2_q) begin
      hi_cnt_d = (hi_cnt_q == '1) ? hi_cnt_q : hi_cnt_q + 1'b1;
    end else begin
      lo_cnt_d = (lo_cnt_q == '1) ? lo_cnt_q : lo_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hi_cnt_q <= '0;
      lo_cnt_q <= '0;
    end else begin
      hi_cnt_q <= hi_cnt_d;
      lo_cnt_q <= lo_cnt_d;
    end
  end

  always_comb begin
    conv_cnt_d = conv_cnt_q;
    bit_d = bit_q;
    skip_d = skip_q;
    word_d = word_q;
    state_d = state_q;
    done_d = 1'b0;
    // oscillator mode never looks at the serial clock for timing
    master_tick = INT_OSC ? osc_tick : sclk_rise;
    conv_end = master_tick && (conv_cnt_q == `CONV_CNT_W'(CONV_LAST));
    // free-running divider, no start command needed
    if (state_q != ST_SLEEP && master_tick) begin
      conv_cnt_d = conv_end ? '0 : conv_cnt_q + 1'b1;
    end
    unique case (state_q)
      ST_IDLE, ST_READY: begin
        if (conv_end) begin
          // a fresh word replaces an unread one
          word_d = i_conv_word;
          done_d = 1'b1;
          state_d = ST_READY;
        end else if (state_q == ST_READY && INT_OSC && master_tick &&
                     conv_cnt_q == `CONV_CNT_W'(EARLY_RISE_AT - 1)) begin
          // unread word withdrawn shortly before the next one
          state_d = ST_IDLE;
        end else if (state_q == ST_READY && !cs_s2_q && (INT_OSC || sclk_rise)) begin
          state_d = ST_SHIFT;
          bit_d = `BIT_CNT_W'(`WORD_LAST_BIT);
          skip_d = ~INT_OSC;
        end
      end
      ST_SHIFT: begin
        // words arriving mid-read are dropped
        if (cs_s2_q) begin
          state_d = ST_IDLE;
        end else if (sclk_fall) begin
          if (skip_q) begin
            skip_d = 1'b0;
          end else if (bit_q == '0) begin
            state_d = ST_IDLE;
          end else begin
            bit_d = bit_q - 1'b1;
          end
        end
      end
      ST_SLEEP: begin
        if (lo_cnt_q >= CNT_W'(WAKE_LOW_CYC)) begin
          state_d = ST_IDLE;
          conv_cnt_d = '0;
        end
      end
    endcase
    if (state_q != ST_SLEEP && hi_cnt_q >= CNT_W'(SLEEP_ENTRY_CYC)) begin
      state_d = ST_SLEEP;
      conv_cnt_d = '0;
      done_d = 1'b0;
    end

    // the word's leading zero doubles as the completion signal
    sdo_d = (state_d == ST_SHIFT) ? word_d[bit_d] : 1'b1;
    sdo_oe_d = ~cs_s2_q;
    asleep_d = (state_d == ST_SLEEP);
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      conv_cnt_q <= '0;
      bit_q <= '0;
      skip_q <= 1'b0;
      word_q <= '0;
      state_q <= ST_IDLE;
      sdo_q <= 1'b1;
      sdo_oe_q <= 1'b0;
      done_q <= 1'b0;
      asleep_q <= 1'b0;
    end else begin
      conv_cnt_q <= conv_cnt_d;
      bit_q <= bit_d;
      skip_q <= skip_d;
      word_q <= word_d;
      state_q <= state_d;
      sdo_q <= sdo_d;
      sdo_oe_q <= sdo_oe_d;
      done_q <= done_d;
      asleep_q <= asleep_d;
    end
  end

  assign o_serial_data_out = sdo_q;
  assign o_serial_data_out_oe = sdo_oe_q;
  assign o_conv_done = done_q;
  assign o_asleep = asleep_q;

endmodule : adc_conversion_clocking

// ===== sim/conv_clk_assertions.sv
`timescale 1ns/1ps
module conv_clk_assertions #(parameter int OSC_DIV_CYC = 4, SLEEP_ENTRY_CYC = 200, WAKE_LOW_CYC = 20,
  parameter bit INT_OSC = 1'b1) (
  // watched ports
  input logic i_clk,
  input logic i_rst_b,
  input logic i_sclk,
  input logic i_cs_b,
  input logic o_serial_data_out_oe,
  input logic o_conv_done,
  input logic o_asleep
);
  // gap bit 31 set: no word since reset or sleep
  logic [31:0] gap_q, gap_d, hi_q, hi_d, lo_q, lo_d;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  always_comb begin
    gap_d = o_conv_done ? '0 : {gap_q[31] | o_asleep, gap_q[30:0] + 31'h1};
    hi_d = i_sclk ? hi_q + 32'h1 : '0;
    lo_d = i_sclk ? '0 : lo_q + 32'h1;
  end
  always_ff @(posedge i_clk or negedge i_rst_b)
    {gap_q, hi_q, lo_q} <= i_rst_b ? {gap_d, hi_d, lo_d} : {32'h80000000, 64'h0};
  done_pulse_a: assert property (o_conv_done |=> !o_conv_done) else $error("long done");
  word_gap_a: assert property (INT_OSC && o_conv_done && !gap_q[31] |-> gap_q == 612*OSC_DIV_CYC-1)
    else $error("word gap");
  oe_off_a: assert property (i_cs_b [*5] |-> !o_serial_data_out_oe) else $error("driven");
  sleep_in_a: assert property (hi_q == SLEEP_ENTRY_CYC + 8 |-> o_asleep) else $error("no sleep");
  sleep_why_a: assert property ($rose(o_asleep) |-> hi_q >= SLEEP_ENTRY_CYC) else $error("early sleep");
  wake_out_a: assert property (lo_q == WAKE_LOW_CYC + 8 |-> !o_asleep) else $error("no wake");
  wake_why_a: assert property ($fell(o_asleep) |-> lo_q >= WAKE_LOW_CYC) else $error("early wake");
  sleep_quiet_a: assert property (o_asleep |-> !o_conv_done) else $error("word in sleep");
  cover property (o_conv_done && !gap_q[31]);
  cover property ($rose(o_asleep));
  cover property ($fell(o_serial_data_out_oe));
endmodule : conv_clk_assertions
bind adc_conversion_clocking conv_clk_assertions #(.OSC_DIV_CYC(OSC_DIV_CYC), .INT_OSC(INT_OSC),
  .SLEEP_ENTRY_CYC(SLEEP_ENTRY_CYC), .WAKE_LOW_CYC(WAKE_LOW_CYC)) u_chk (.*);

// ===== sim/host_model.sv
`timescale 1ns/1ps
module host_model (
  // host pins
  input logic i_clk,
  input logic i_sdo,
  input logic i_oe,
  output logic o_sclk = 1'b0,
  output logic o_cs_b = 1'b1
);
  // released line reads inverted, never the last bit
  wire sdo_w = i_oe ? i_sdo : ~i_sdo;
  task automatic hold(input logic v, input int n);
    o_sclk <= v;
    repeat (n) @(posedge i_clk);
  endtask : hold
  // 32-cycle phases keep sclk under 2 MHz
  task automatic read(output logic [23:0] w, input bit ext);
    @(posedge i_clk);
    o_cs_b <= 1'b0;
    // external clock: first rise shows the lead bit, its fall shifts nothing
    if (ext) begin
      hold(1'b0, 32);
      hold(1'b1, 32);
    end
    for (int i = 0; i < 24; i++) begin
      hold(1'b0, 32);
      w = {w[22:0], sdo_w};
      hold(1'b1, 32);
    end
    hold(1'b0, 32);
    o_cs_b <= 1'b1;
  endtask : read
endmodule : host_model

// ===== sim/test_adc_conversion_clocking.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; $display("wrong value %0t %h", $time, g); end end
module test_adc_conversion_clocking import adc_conversion_clocking_pkg::*;;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_sclk, i_cs_b, o_serial_data_out, o_serial_data_out_oe, o_conv_done, o_asleep;
  logic [23:0] w;
  conv_word_t i_conv_word = '0, rows [4] = '{24'h4abcde, 24'h2fffff, 24'h000001, 24'h0a5a5a};
  int bad_count = 0, n_checks = 0;
  logic ext_sclk, ext_cs_b, ext_sdo, ext_oe, ext_done, ext_asleep, ext_seen = 1'b0;
  int ticks;
  adc_conversion_clocking #(.INT_OSC(1'b1), .OSC_DIV_CYC(4), .SLEEP_ENTRY_CYC(200), .WAKE_LOW_CYC(20))
    u_adc_conversion_clocking (.*);
  host_model u_host_model (.i_clk, .i_sdo(o_serial_data_out), .i_oe(o_serial_data_out_oe), .o_sclk(i_sclk),
    .o_cs_b(i_cs_b));
  adc_conversion_clocking #(.INT_OSC(1'b0), .OSC_DIV_CYC(4), .SLEEP_ENTRY_CYC(200), .WAKE_LOW_CYC(20))
    u_adc_conversion_clocking_ext (.i_clk, .i_rst_b, .i_sclk(ext_sclk), .i_cs_b(ext_cs_b),
    .o_serial_data_out(ext_sdo), .o_serial_data_out_oe(ext_oe), .i_conv_word, .o_conv_done(ext_done),
    .o_asleep(ext_asleep));
  host_model u_host_ext (.i_clk, .i_sdo(ext_sdo), .i_oe(ext_oe), .o_sclk(ext_sclk), .o_cs_b(ext_cs_b));
  // sticky copy: the done pulse is shorter than one pin period
  always @(posedge i_clk) ext_seen <= ext_seen | (ext_done === 1'b1);
  initial forever #4 i_clk = ~i_clk;
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task automatic row(input int i);
    @(posedge i_clk);
    i_conv_word <= rows[i];
    for (int n = 0; n < 3000 && o_conv_done !== 1'b1; n++) @(negedge i_clk);
    `CHK(o_conv_done, 1'b1)
    u_host_model.read(w, 1'b0);
    `CHK(w, rows[i])
    $display("test row %0d done", i);
  endtask : row
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(negedge i_clk);
    `CHK({o_serial_data_out, o_serial_data_out_oe, o_conv_done, o_asleep}, 4'b1000)
    $display("test reset done");
    for (int i = 0; i < 3; i++) row(i);
    u_host_model.hold(1'b1, 260);
    `CHK(o_asleep, 1'b1)
    u_host_model.hold(1'b0, 40);
    `CHK(o_asleep, 1'b0)
    $display("test sleep done");
    row(3);
    for (ticks = 0; ticks < 700 && !ext_seen; ticks++) begin
      u_host_ext.hold(1'b1, 4);
      u_host_ext.hold(1'b0, 4);
    end
    `CHK(ticks, 612)
    u_host_ext.read(w, 1'b1);
    `CHK(w, rows[3])
    `CHK(ext_asleep, 1'b0)
    $display("test external clock done");
    results();
  end
  initial begin
    repeat (40000) @(posedge i_clk);
    bad_count++;
    results();
  end
endmodule : test_adc_conversion_clocking
